// [nvmc_access_regs.sv]
// AHB-Lite control register front end of the embedded flash controller
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_consts.svh"

module nvmc_access_regs
    import nvmc_pkg::*;
(
    input  wire logic              clk_sys,            // subsystem bus clock
    input  wire logic              sys_rst,            // sync reset, active high
    input  wire logic              ce,                 // clock enable
    input  wire logic              hsel,               // slave select
    input  wire logic [8:0]        haddr,              // byte offset
    input  wire logic [1:0]        htrans,             // transfer type
    input  wire logic              hwrite,             // write when high
    input  wire logic [2:0]        hsize,              // transfer size
    input  wire logic [31:0]       hwdata,             // write data
    input  wire logic              hready,             // bus ready in
    input  wire nvmc_master_type   hmaster_class,      // class of current master
    output var  logic [31:0]       hrdata,             // read data
    output logic                   hreadyout,          // slave ready
    output logic                   hresp,              // always okay
    input  wire logic [7:0]        wait_cycle_setting, // wait cycles from sysreg
    input  wire logic              dpd_request,        // power-down requested
    input  wire logic              normal_mode_exit,   // leaving normal mode
    input  wire logic [1023:0]     asm_buf_data,       // assembly buffer contents
    input  wire nvmc_core_in_type  core_in,            // array side status
    output var  nvmc_core_out_type core_out,           // array side controls
    output var  logic [1023:0]     write_data_buffer,  // write data buffer
    output var  logic [31:0]       shadow_copy_status, // shadow copy status word
    output var  logic [31:0]       array_busy_status,  // busy status word
    output var  logic              controller_irq      // interrupt line
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WR   = 4'b0010,
        ST_RD1  = 4'b0100,
        ST_RD2  = 4'b1000
    } nvmc_bus_state_type;

    nvmc_bus_state_type state_r;
    nvmc_bus_state_type state_nxt;

    logic [8:0]   a_addr_r;
    logic [3:0]   a_be_r;
    logic [2:0]   a_code_r;
    logic [2:0]   holder_r;
    logic [1:0]   enable_r;
    logic [1:0]   page_stat_r;
    logic         page_lock_r;
    logic [3:0]   xfer_size_r;
    logic [31:0]  command_r;
    logic [10:0]  int_en_r;
    logic         launch_r;
    logic         rdclr_r;
    logic [31:0]  wdb_r [32];
    logic [31:0]  rd_val;
    logic [31:0]  status_word;
    logic         take;
    logic         is_holder;
    logic         wr_now;
    logic [31:0]  wr_data;
    logic [2:0]   req_val;
    logic         relinquish;
    logic         cmd_wr;
    logic         cmd_blocked;
    logic         cmd_busy;
    logic         cmd_valid;
    logic [7:0]   cmd_field;
    logic [31:0]  cmd_merged;
    logic         set_busycmd;
    logic         set_denied;
    logic         flag_busycmd;
    logic         flag_denied;
    logic         dpd_state;
    logic [2:0]   clr_hit;
    logic [10:0]  irq_src;

    // byte lanes of an AHB-Lite transfer
    function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] lo);
        logic [3:0] be;
        be = 4'hf;
        if (sz == 3'h0) begin
            be = 4'(4'h1 << lo);
        end else if (sz == 3'h1) begin
            be = lo[1] ? 4'hc : 4'h3;
        end
        return be;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign take      = hsel && hready && htrans[1];
    assign wr_now    = (state_r == ST_WR);
    assign is_holder = holder_r[2] && (a_code_r == holder_r);
    assign hresp     = 1'b0;
    // reads take one wait state so a write just before is already visible
    assign hreadyout = (state_r != ST_RD1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE, ST_WR, ST_RD2: begin
                if (take) begin
                    state_nxt = hwrite ? ST_WR : ST_RD1;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RD1: begin
                state_nxt = ST_RD2;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            a_addr_r <= 9'h0;
            a_be_r   <= 4'h0;
            a_code_r <= 3'h0;
        end else if (ce && take && (state_r != ST_RD1)) begin
            a_addr_r <= haddr;
            a_be_r   <= lanes(hsize, haddr[1:0]);
            a_code_r <= {1'b1, hmaster_class};
        end
    end

    always_comb begin
        wr_data = 32'h0;
        if (a_be_r[0]) wr_data[7:0]   = hwdata[7:0];
        if (a_be_r[1]) wr_data[15:8]  = hwdata[15:8];
        if (a_be_r[2]) wr_data[23:16] = hwdata[23:16];
        if (a_be_r[3]) wr_data[31:24] = hwdata[31:24];
    end

    // access request: only the low lane at the word address is honoured
    assign req_val    = hwdata[2:0];
    assign relinquish = wr_now && (a_addr_r == `NVMC_OFS_ACC_REQ) && a_be_r[0]
                        && is_holder && (req_val == `NVMC_REQ_RELEASE);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            holder_r <= `NVMC_RST_ACC_REQ;
        end else if (ce && wr_now && (a_addr_r == `NVMC_OFS_ACC_REQ) && a_be_r[0]) begin
            if (req_val == `NVMC_REQ_SYS_TAKE && a_code_r == {1'b1, NVMC_MST_SYS}) begin
                holder_r <= a_code_r;
            end else if (req_val == `NVMC_REQ_GRAB && !holder_r[2]) begin
                // a grab request while held is dropped; the requester reads the holder
                holder_r <= a_code_r;
            end else if (relinquish) begin
                holder_r <= {1'b0, holder_r[1:0]};
            end
        end
    end

    // control registers only change for the holder
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable_r    <= `NVMC_RST_ENABLE;
            page_stat_r <= `NVMC_RST_PAGE_STAT;
            page_lock_r <= `NVMC_RST_PAGE_LOCK;
            xfer_size_r <= `NVMC_RST_XFER_SIZE;
            int_en_r    <= `NVMC_RST_INT_EN;
            command_r   <= `NVMC_RST_COMMAND;
        end else if (ce && wr_now && is_holder) begin
            case (a_addr_r)
                `NVMC_OFS_ENABLE:    enable_r    <= wr_data[1:0];
                `NVMC_OFS_PAGE_STAT: page_stat_r <= wr_data[1:0];
                `NVMC_OFS_PAGE_LOCK: page_lock_r <= wr_data[0];
                `NVMC_OFS_XFER_SIZE: xfer_size_r <= wr_data[3:0];
                `NVMC_OFS_INT_EN:    int_en_r    <= wr_data[10:0];
                `NVMC_OFS_COMMAND:   command_r   <= merge(command_r, hwdata, a_be_r);
                default: begin
                end
            endcase
        end
    end

    // write data buffer is open to any master
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < 32; i++) begin
                wdb_r[i] <= 32'h0;
            end
        end else if (ce) begin
            if (relinquish || normal_mode_exit) begin
                for (int i = 0; i < 32; i++) begin
                    wdb_r[i] <= 32'h0;
                end
            end else if (wr_now && a_addr_r[8:7] == `NVMC_WIN_WDB) begin
                wdb_r[a_addr_r[6:2]] <= merge(wdb_r[a_addr_r[6:2]], hwdata, a_be_r);
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            write_data_buffer[i*32 +: 32] = wdb_r[i];
        end
    end

    // command acceptance
    assign cmd_wr      = wr_now && is_holder && (a_addr_r == `NVMC_OFS_COMMAND);
    assign cmd_merged  = merge(command_r, hwdata, a_be_r);
    assign cmd_field   = cmd_merged[`NVMC_CMD_FIELD_MSB:`NVMC_CMD_FIELD_LSB];
    assign cmd_valid   = (cmd_field != 8'h0) && (cmd_field <= `NVMC_CMD_MAX_CODE);
    assign cmd_blocked = flag_busycmd || flag_denied;
    // launch in flight counts as busy until the array raises its own flag
    assign cmd_busy    = (|core_in.busy) || launch_r;
    assign set_busycmd = cmd_wr && !cmd_blocked && cmd_busy;
    assign set_denied  = core_in.prot_denied
                         || (cmd_wr && !cmd_blocked && !cmd_busy && !cmd_valid);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            launch_r <= 1'b0;
            rdclr_r  <= 1'b0;
        end else if (ce) begin
            launch_r <= cmd_wr && !cmd_blocked && !cmd_busy && cmd_valid;
            rdclr_r  <= relinquish;
        end
    end

    assign clr_hit = (wr_now && is_holder && a_addr_r == `NVMC_OFS_FLAG_CLR)
                     ? wr_data[2:0] : 3'h0;

    nvmc_sticky_flag u_busycmd (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .set_i   (set_busycmd),
        .clr_i   (clr_hit[`NVMC_CLR_BUSYCMD]),
        .flag_r  (flag_busycmd)
    );

    nvmc_sticky_flag u_denied (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .set_i   (set_denied),
        .clr_i   (clr_hit[`NVMC_CLR_DENIED]),
        .flag_r  (flag_denied)
    );

    assign irq_src = {set_busycmd, set_denied, core_in.op_done, core_in.double_error_flag, core_in.single_correct_flag,
                      core_in.refresh, core_in.wcount_over, core_in.lock_fail,
                      core_in.wverify_fail, core_in.everify_fail, core_in.verify_fail};

    nvmc_sticky_flag u_irq (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .set_i   (|(irq_src & int_en_r)),
        .clr_i   (clr_hit[`NVMC_CLR_IRQ]),
        .flag_r  (controller_irq)
    );

    nvmc_dpd_timer u_dpd (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .ce      (ce),
        .req     (dpd_request),
        .dpd_r   (dpd_state)
    );

    always_comb begin
        status_word = 32'h0;
        status_word[31:`NVMC_ST_HOLDER_LSB] = holder_r;
        status_word[`NVMC_ST_BUSYCMD]       = flag_busycmd;
        status_word[`NVMC_ST_DENIED]        = flag_denied;
        status_word[`NVMC_ST_PWR_DOWN]      = dpd_state;
        status_word[16:`NVMC_ST_ECC_LSB]    = core_in.ecc_seg;
        status_word[8:`NVMC_ST_FLAGS_LSB]   = {core_in.double_error_flag, core_in.single_correct_flag, core_in.refresh,
                                               core_in.wcount_over, core_in.lock_fail,
                                               core_in.wverify_fail, core_in.everify_fail,
                                               core_in.verify_fail};
    end

    // read mux; non-holders see zero everywhere but the holder code and the write data buffer window
    always_comb begin
        rd_val = 32'h0;
        if (a_addr_r[8:7] == `NVMC_WIN_ASM) begin
            if (is_holder) begin
                rd_val = asm_buf_data[a_addr_r[6:2]*32 +: 32];
            end
        end else if (a_addr_r[8:7] == `NVMC_WIN_WDB) begin
            rd_val = wdb_r[a_addr_r[6:2]];
        end else begin
            case (a_addr_r)
                `NVMC_OFS_ACC_REQ: rd_val = {29'h0, holder_r};
                `NVMC_OFS_STATUS:  rd_val = is_holder ? status_word
                                            : {holder_r, 29'h0};
                default: begin
                    if (is_holder) begin
                        case (a_addr_r)
                            `NVMC_OFS_PAGE_STAT: rd_val = {30'h0, page_stat_r};
                            `NVMC_OFS_WAIT_CYC:  rd_val = {24'h0, wait_cycle_setting};
                            `NVMC_OFS_PWR_DOWN:  rd_val = {31'h0, dpd_state};
                            `NVMC_OFS_ENABLE:    rd_val = {30'h0, enable_r};
                            `NVMC_OFS_PAGE_LOCK: rd_val = {31'h0, page_lock_r};
                            `NVMC_OFS_XFER_SIZE: rd_val = {28'h0, xfer_size_r};
                            `NVMC_OFS_COMMAND:   rd_val = command_r;
                            `NVMC_OFS_INT_EN:    rd_val = {21'h0, int_en_r};
                            default:             rd_val = 32'h0;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hrdata <= 32'h0;
        end else if (ce && state_r == ST_RD1) begin
            hrdata <= rd_val;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            shadow_copy_status <= 32'h0;
            array_busy_status  <= 32'h0;
        end else if (ce) begin
            shadow_copy_status <= 32'h0;
            array_busy_status  <= {30'h0, core_in.busy};
        end
    end

    always_comb begin
        core_out.array_en      = enable_r[0];
        core_out.cache_bypass  = enable_r[1];
        core_out.page_lock     = page_lock_r;
        core_out.page_stat_sel = page_stat_r;
        core_out.xfer_size     = xfer_size_r;
        core_out.cmd_word      = command_r;
        core_out.cmd_launch    = launch_r;
        core_out.rdbuf_clear   = rdclr_r;
    end
endmodule

`default_nettype wire

// [nvmc_consts.svh]
// offsets, field positions, reset values and timing counts of the flash control register front end
`ifndef NVMC_CONSTS_SVH
`define NVMC_CONSTS_SVH

`define NVMC_OFS_STATUS      9'h120
`define NVMC_OFS_PAGE_STAT   9'h128
`define NVMC_OFS_WAIT_CYC    9'h12c
`define NVMC_OFS_PWR_DOWN    9'h130
`define NVMC_OFS_ENABLE      9'h134
`define NVMC_OFS_PAGE_LOCK   9'h140
`define NVMC_OFS_XFER_SIZE   9'h144
`define NVMC_OFS_COMMAND     9'h148
`define NVMC_OFS_INT_EN      9'h154
`define NVMC_OFS_FLAG_CLR    9'h158
`define NVMC_OFS_ACC_REQ     9'h1fc
`define NVMC_WIN_ASM         2'h0
`define NVMC_WIN_WDB         2'h1

`define NVMC_RST_ENABLE      2'h1
`define NVMC_RST_PAGE_STAT   2'h0
`define NVMC_RST_PAGE_LOCK   1'h0
`define NVMC_RST_XFER_SIZE   4'h0
`define NVMC_RST_COMMAND     32'h0
`define NVMC_RST_INT_EN      11'h0
`define NVMC_RST_ACC_REQ     3'h0

`define NVMC_REQ_GRAB        3'h1
`define NVMC_REQ_RELEASE     3'h0
`define NVMC_REQ_SYS_TAKE    3'h3

`define NVMC_CLR_IRQ         0
`define NVMC_CLR_DENIED      1
`define NVMC_CLR_BUSYCMD     2

`define NVMC_ST_HOLDER_LSB   29
`define NVMC_ST_BUSYCMD      19
`define NVMC_ST_DENIED       18
`define NVMC_ST_PWR_DOWN     17
`define NVMC_ST_ECC_LSB      9
`define NVMC_ST_FLAGS_LSB    1

`define NVMC_CMD_FIELD_MSB   31
`define NVMC_CMD_FIELD_LSB   24
`define NVMC_CMD_MAX_CODE    8'h0f

`define NVMC_DPD_TIME_NS     5000
`define NVMC_CLK_PERIOD_NS   10
`define NVMC_DPD_CYCLES      (`NVMC_DPD_TIME_NS / `NVMC_CLK_PERIOD_NS)

`endif

// [nvmc_pkg.sv]
// types shared by the flash control register front end
package nvmc_pkg;

    typedef enum logic [1:0] {
        NVMC_MST_SYS = 2'h0,
        NVMC_MST_FAB = 2'h2,
        NVMC_MST_OTH = 2'h3
    } nvmc_master_type;

    // events and levels reported by the array side
    typedef struct packed {
        logic [7:0] ecc_seg;
        logic       double_error_flag;
        logic       single_correct_flag;
        logic       refresh;
        logic       wcount_over;
        logic       lock_fail;
        logic       wverify_fail;
        logic       everify_fail;
        logic       verify_fail;
        logic       op_done;
        logic       prot_denied;
        logic [1:0] busy;
    } nvmc_core_in_type;

    // settings driven towards the array side
    typedef struct packed {
        logic        array_en;
        logic        cache_bypass;
        logic        page_lock;
        logic [1:0]  page_stat_sel;
        logic [3:0]  xfer_size;
        logic [31:0] cmd_word;
        logic        cmd_launch;
        logic        rdbuf_clear;
    } nvmc_core_out_type;

endpackage

// [nvmc_sticky_flag.sv]
// sticky flag where a set wins over a same-cycle clear
`timescale 1ns/1ps
`default_nettype none

module nvmc_sticky_flag (
    input  wire logic clk_sys,  // bus clock
    input  wire logic sys_rst,  // sync reset
    input  wire logic ce,       // clock enable
    input  wire logic set_i,    // set request
    input  wire logic clr_i,    // clear request
    output var  logic flag_r    // flag state
);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_r <= 1'b0;
        end else if (ce) begin
            if (set_i) begin
                flag_r <= 1'b1;
            end else if (clr_i) begin
                flag_r <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// [nvmc_dpd_timer.sv]
// deep power-down entry delay
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_consts.svh"

module nvmc_dpd_timer (
    input  wire logic clk_sys,  // bus clock
    input  wire logic sys_rst,  // sync reset
    input  wire logic ce,       // clock enable
    input  wire logic req,      // power-down requested
    output var  logic dpd_r     // array in deep power-down
);
    localparam logic [9:0] DPD_CNT = 10'(`NVMC_DPD_CYCLES);
    logic [9:0] cnt_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_r <= 10'h0;
            dpd_r <= 1'b0;
        end else if (ce) begin
            if (!req) begin
                // leaving power-down reports operational at once
                cnt_r <= 10'h0;
                dpd_r <= 1'b0;
            end else if (cnt_r != DPD_CNT) begin
                cnt_r <= cnt_r + 10'h1;
            end else begin
                dpd_r <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// [nvmc_access_regs_properties.sv]
// port assertions of the flash control register front end
`timescale 1ns/1ps
`default_nettype none
module nvmc_access_regs_properties
    import nvmc_pkg::*;
(
    input wire logic              clk_sys,           // bus clock
    input wire logic              sys_rst,           // sync reset
    input wire logic              ce,                // clock enable
    input wire logic              hreadyout,         // slave ready
    input wire logic              hresp,             // response
    input wire nvmc_core_in_type  core_in,           // array status
    input wire nvmc_core_out_type core_out,          // array controls
    input wire logic [1023:0]     write_data_buffer, // write buffer
    input wire logic [31:0]       array_busy_status, // busy word
    input wire logic              controller_irq     // irq line
);
    // frozen cycles are skipped, since ce low holds every register
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst || !ce);
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    read_wait_a: assert property (!hreadyout |=> hreadyout)
        else $error("read wait over one cycle");
    launch_pulse_a: assert property (core_out.cmd_launch |=> !core_out.cmd_launch)
        else $error("launch longer than one cycle");
    launch_idle_a: assert property (core_out.cmd_launch |-> $past(core_in.busy) == 2'h0)
        else $error("launch while busy");
    clear_pulse_a: assert property (core_out.rdbuf_clear |=> !core_out.rdbuf_clear)
        else $error("read buffer clear too long");
    clear_empty_a: assert property (core_out.rdbuf_clear |-> write_data_buffer == '0)
        else $error("write buffer kept on release");
    busy_mirror_a: assert property ($past(!sys_rst) |->
        array_busy_status == {30'h0, $past(core_in.busy)})
        else $error("busy word wrong");
    reset_vals_a: assert property ($past(sys_rst) |-> core_out.array_en
        && !controller_irq && !core_out.cmd_launch)
        else $error("reset values wrong");
endmodule
bind nvmc_access_regs nvmc_access_regs_properties i_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .hreadyout(hreadyout), .hresp(hresp),
    .core_in(core_in), .core_out(core_out), .write_data_buffer(write_data_buffer),
    .array_busy_status(array_busy_status), .controller_irq(controller_irq));
`default_nettype wire

// [nvmc_array_model.sv]
// array side model: busy for a while after each launch, then done
`timescale 1ns/1ps
`default_nettype none
module nvmc_array_model
    import nvmc_pkg::*;
#(
    parameter int BUSY_LEN = 6
)
(
    input  wire logic              clk_sys,  // bus clock
    input  wire logic              sys_rst,  // sync reset
    input  wire nvmc_core_out_type core_out, // controls
    output var  nvmc_core_in_type  core_in   // status
);
    int cnt_r;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) cnt_r <= 0;
        else if (core_out.cmd_launch) cnt_r <= BUSY_LEN;
        else if (cnt_r > 0) cnt_r <= cnt_r - 1;
    end
    always_comb begin
        core_in = '0;
        core_in.busy = {1'b0, cnt_r > 0};
        core_in.op_done = (cnt_r == 1);
    end
endmodule
`default_nettype wire

// [nvmc_access_regs_test.sv]
// self-checking bench of the flash control register front end
`timescale 1ns/1ps
`default_nettype none
module nvmc_access_regs_test import nvmc_pkg::*; ();
    logic clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0, dpd = 0, nme = 0, hro, hresp, irq;
    logic [8:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsz = 3'h2;
    logic [7:0] wcs = '0;
    logic [31:0] hwdata = '0, hrdata, v, sh, bs;
    logic [1023:0] asm = '0, wdb;
    nvmc_master_type cls = NVMC_MST_FAB;
    nvmc_core_in_type ci;
    nvmc_core_out_type co;
    int err_count = 0, comparisons = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    nvmc_access_regs i_nvmc_access_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsz),
        .hwdata(hwdata), .hready(1'b1), .hmaster_class(cls), .hrdata(hrdata),
        .hreadyout(hro), .hresp(hresp), .wait_cycle_setting(wcs), .dpd_request(dpd),
        .normal_mode_exit(nme), .asm_buf_data(asm), .core_in(ci), .core_out(co),
        .write_data_buffer(wdb), .shadow_copy_status(sh), .array_busy_status(bs),
        .controller_irq(irq));
    nvmc_array_model i_nvmc_array_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .core_out(co), .core_in(ci));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // answer taken at the edge where ready was high; sampled late in that cycle
    task xfer(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic r;
        hsel = 1;
        htrans = 2'h2;
        hwrite = w;
        haddr = a;
        @(posedge clk_sys);
        #1 hsel = 0;
        htrans = 2'h0;
        hwdata = d;
        n = 0;
        do begin
            #8 r = hro;
            q = hrdata;
            @(posedge clk_sys);
            #1 n++;
        end while (r !== 1'b1 && n < 4);
        if (r !== 1'b1) err_count++;
    endtask
    task wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task rd(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, '0, q);
        chk($sformatf("reg %h", a), q, e);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict;
        end
    end
    initial begin
        v = $urandom(67172);
        wcs = $urandom;
        for (int i = 0; i < 32; i++) asm[i*32 +: 32] = $urandom;
        repeat (10) @(posedge clk_sys);
        #1 sys_rst = 0;
        rd(9'h1fc, 0);
        rd(9'h120, 0);
        wr(9'h134, 0);
        hsz = 3'h0;
        wr(9'h1fc, 1);
        hsz = 3'h2;
        rd(9'h1fc, 6);
        rd(9'h134, 1);
        rd(9'h120, 32'hc0000000);
        cls = NVMC_MST_OTH;
        wr(9'h1fc, 1);
        rd(9'h1fc, 6);
        cls = NVMC_MST_FAB;
        wr(9'h144, v);
        rd(9'h144, v & 32'hf);
        chk("xfer", co.xfer_size, v & 32'hf);
        wr(9'h134, 3);
        rd(9'h134, 3);
        chk("bypass", co.cache_bypass, 1);
        wr(9'h140, 1);
        rd(9'h140, 1);
        chk("lock", co.page_lock, 1);
        wr(9'h140, 0);
        rd(9'h140, 0);
        wr(9'h154, v);
        rd(9'h154, v & 32'h7ff);
        rd(9'h12c, wcs);
        v = $urandom % 32;
        rd(v[8:0] << 2, asm[v*32 +: 32]);
        wr(9'h154, 32'h100);
        wr(9'h148, 32'h01000000);
        wr(9'h148, 32'h0f000000);
        rd(9'h120, 32'hc0080000);
        chk("busy word", bs, 1);
        repeat (12) @(posedge clk_sys);
        #1 chk("irq", irq, 1);
        wr(9'h158, 4);
        rd(9'h120, 32'hc0000000);
        wr(9'h158, 1);
        @(posedge clk_sys);
        #1 chk("irq", irq, 0);
        wr(9'h148, 32'h20000000);
        rd(9'h120, 32'hc0040000);
        wr(9'h158, 2);
        rd(9'h120, 32'hc0000000);
        v = $urandom;
        wr(9'h80, v);
        chk("wdb", wdb[31:0], v);
        wr(9'h1fc, 0);
        chk("wdb", wdb[31:0], 0);
        rd(9'h1fc, 2);
        rd(9'h134, 0);
        rd(9'h000, 0);
        cls = NVMC_MST_SYS;
        wr(9'h80, v);
        wr(9'h1fc, 3);
        rd(9'h1fc, 4);
        chk("wdb", wdb[31:0], v);
        dpd = 1;
        repeat (510) @(posedge clk_sys);
        #1 rd(9'h120, 32'h80020000);
        nme = 1;
        @(posedge clk_sys);
        #1 nme = 0;
        @(posedge clk_sys);
        chk("wdb", wdb[31:0], 0);
        chk("busy word", bs, 0);
        give_verdict;
    end
endmodule
`default_nettype wire
